// >>> inc/pdb_pkg.sv
package pdb_pkg;

	////////////////////////////////////////////////////////////////////////
	// Clock and strobe timing.

	localparam int CLK_PERIOD_NS = 20;
	// Least row strobe precharge time that the memory devices need.
	localparam int T_PRECHARGE_NS = 150;
	// Delay from row strobe to the multiplexer switching to the column address.
	localparam int T_MUX_NS = 40;
	// Delay from row strobe to the column strobe.
	localparam int T_CAS_NS = 80;

	// Least times round up to whole cycles.
	localparam int PRECH_CYC = (T_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MUX_CYC = (T_MUX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CAS_CYC = (T_CAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////
	// Address map.

	localparam logic [15:0] LOW_PAGE_BASE = 16'h0000;
	localparam logic [15:0] LOW_PAGE_LAST = 16'h7fff;
	localparam logic [15:0] UPPER_PAGE_BASE = 16'h8000;
	localparam logic [15:0] VIDEO_WINDOW_BASE = 16'hf800;
	localparam int ADDR_PAGE_BIT = 15;
	localparam int ADDR_ROWGRP_BIT = 14;
	localparam int ROW_ADDR_LSB = 0;
	localparam int COL_ADDR_LSB = 7;
	localparam int ARRAY_ADDR_W = 7;

	////////////////////////////////////////////////////////////////////////
	// The memory page port, write-only at I/O address 0xff.

	localparam logic [7:0] PAGE_PORT_ADDR = 8'hff;
	localparam logic [7:0] PAGE_PORT_RESET = 8'h00;
	localparam int PORT_PAGE_LSB = 0;
	localparam int PORT_PAGE_MSB = 3;
	localparam int PORT_BANK_LSB = 1;
	localparam int PORT_VIDEO_BIT = 7;

endpackage

// >>> hw/pdb_strobe_seq.sv
`timescale 1ns/1ps

module pdb_strobe_seq
	import pdb_pkg::*;
#(
	parameter int PRECH_CYCLES = PRECH_CYC,
	parameter int MUX_CYCLES = MUX_CYC,
	parameter int CAS_CYCLES = CAS_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Cycle request
	input wire logic start,
	input wire logic refresh,
	// Strobe states
	output logic ras_on,
	output logic mux_on,
	output logic cas_on,
	output logic started
);

	localparam int CNT_MAX = (PRECH_CYCLES > CAS_CYCLES) ? PRECH_CYCLES : CAS_CYCLES;
	localparam int CW = $clog2(CNT_MAX + 1);

	if (MUX_CYCLES < 1 || CAS_CYCLES <= MUX_CYCLES || PRECH_CYCLES < 1) begin : g_bad_timing
		$error("Strobe delays must satisfy 1 <= mux < cas and precharge >= 1.");
	end

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_ACTIVE = 2'b01,
		SEQ_PRECH = 2'b10
	} pdb_seq_state_t;

	pdb_seq_state_t state_r;
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	logic refresh_r;

	assign cnt_nxt = cnt_r + 1'b1;

	////////////////////////////////////////////////////////////////////////
	// Row strobe with precharge extension: a new row strobe waits in
	// precharge until the devices have rested long enough.

	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= SEQ_IDLE;
			cnt_r <= '0;
			ras_on <= 1'b0;
			started <= 1'b0;
			refresh_r <= 1'b0;
		end else begin
			started <= 1'b0;
			unique case (state_r)
				SEQ_IDLE: begin
					if (start) begin
						state_r <= SEQ_ACTIVE;
						ras_on <= 1'b1;
						started <= 1'b1;
						refresh_r <= refresh;
						cnt_r <= '0;
					end
				end
				SEQ_ACTIVE: begin
					if (!start) begin
						state_r <= SEQ_PRECH;
						ras_on <= 1'b0;
						cnt_r <= '0;
					end else if (cnt_r != CW'(CNT_MAX)) begin
						cnt_r <= cnt_nxt;
					end
				end
				SEQ_PRECH: begin
					if (cnt_nxt == CW'(PRECH_CYCLES)) begin
						state_r <= SEQ_IDLE;
						cnt_r <= '0;
					end else begin
						cnt_r <= cnt_nxt;
					end
				end
				default: begin
					state_r <= SEQ_IDLE;
					ras_on <= 1'b0;
					cnt_r <= '0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Delay chain. A refresh cycle never enters it, so it never produces
	// the column strobe.

	always_ff @(posedge clk) begin
		if (rst) begin
			mux_on <= 1'b0;
			cas_on <= 1'b0;
		end else if (state_r == SEQ_ACTIVE && start && !refresh_r) begin
			if (cnt_nxt >= CW'(MUX_CYCLES)) begin
				mux_on <= 1'b1;
			end
			if (cnt_nxt >= CW'(CAS_CYCLES)) begin
				cas_on <= 1'b1;
			end
		end else begin
			mux_on <= 1'b0;
			cas_on <= 1'b0;
		end
	end

endmodule

// >>> hw/pdb_board_ctrl.sv
`timescale 1ns/1ps

// Operation
// - Page zero answers 0000-7FFF whatever the port holds.
// - Pages 1-15 answer 8000-FFFF, only one enabled at a time.
// - Port bits 0-3 with A14/A15 pick the upper page and row group.
// - Board is one of eight banks, each a pair of 32K pages.
// - Board holds one 32K page or both pages, 16 or 32 devices.
// - Memory cycle starts row strobe; refresh keeps it out of the delay chain.
// - Multiplexer switches to column address first, then column strobe asserts.
// - Row strobe precharge is stretched to the devices' least time.
// - Write strobe in a memory cycle writes the array, else it reads.
// - Data bus is driven only on a read strobe to a selected page.
// - Memory select OR refresh gates the row strobe into the array.
// - Video enable bit blocks F800-FFFF on pages 1-15, not page zero.
// - Address range, page and port bit 7 form the upper decoder gate.
// - With the upper decoder gate off, upper pages are never accessed.
// - I/O write to address FF loads the 8-bit page port.
// - Reset clears the page port to zero.
module pdb_board_ctrl
	import pdb_pkg::*;
#(
	parameter int BANK_ID = 0,
	parameter bit POP_64K = 1'b1,
	parameter bit SINGLE_HALF = 1'b0,
	parameter int PRECH_CYCLES = PRECH_CYC,
	parameter int MUX_CYCLES = MUX_CYC,
	parameter int CAS_CYCLES = CAS_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// System bus address, data and strobes
	input wire logic [15:0] bus_addr,
	input wire logic [7:0] bus_data_in,
	input wire logic memory_cycle_n,
	input wire logic io_cycle_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic refresh_request_n,
	// System bus data return
	output logic [7:0] bus_data_out,
	output logic bus_data_oe,
	// Memory array
	input wire logic [7:0] array_dout,
	output logic [7:0] array_din,
	output logic [ARRAY_ADDR_W-1:0] array_addr,
	output logic [3:0] ras_row_n,
	output logic cas_n,
	output logic row_column_select,
	output logic array_we_n,
	// Status
	output logic [7:0] page_select_port,
	output logic board_selected
);

	if (BANK_ID < 0 || BANK_ID > 7) begin : g_bad_bank
		$error("BANK_ID must lie in 0 to 7.");
	end

	localparam logic [2:0] BANK = 3'(BANK_ID);

	////////////////////////////////////////////////////////////////////////
	// Helpers.

	// A half of the board is fitted when the board is fully populated or
	// when it is the single page that a half-populated board carries.
	function automatic logic half_fitted(input logic half);
		half_fitted = POP_64K || (half == SINGLE_HALF);
	endfunction

	// Page number that one half of this board serves.
	function automatic logic [3:0] half_page(input logic half);
		half_page = {BANK, half};
	endfunction

	// One row strobe per group of eight devices: page half and A14.
	function automatic logic [3:0] row_onehot(input logic half, input logic a14);
		row_onehot = 4'h1 << {half, a14};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Page port.

	logic [7:0] page_port_r;
	logic page_port_write_strobe;

	// Only a write is decoded; a read of the same address leaves the data
	// bus alone, so software cannot read the page back.
	assign page_port_write_strobe = !io_cycle_n && !wr_n
		&& bus_addr[7:0] == PAGE_PORT_ADDR;

	always_ff @(posedge clk) begin
		if (rst) begin
			page_port_r <= PAGE_PORT_RESET;
		end else if (page_port_write_strobe) begin
			page_port_r <= bus_data_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Address decode.

	logic [3:0] upper_page;
	logic in_low_page;
	logic in_upper_page;
	logic in_video_window;
	logic video_enable;
	logic upper_gate;
	logic sel_half0;
	logic sel_half1;
	logic mem_sel;
	logic sel_half;
	logic refresh;

	assign upper_page = page_port_r[PORT_PAGE_MSB:PORT_PAGE_LSB];
	assign video_enable = page_port_r[PORT_VIDEO_BIT];
	assign refresh = !refresh_request_n;

	assign in_low_page = bus_addr >= LOW_PAGE_BASE && bus_addr <= LOW_PAGE_LAST;
	assign in_upper_page = bus_addr[ADDR_PAGE_BIT];
	assign in_video_window = bus_addr >= VIDEO_WINDOW_BASE;

	// The upper decoder is gated off for page number zero (no upper page
	// chosen) and for the video window while the video bit is set.
	assign upper_gate = in_upper_page && upper_page != 4'h0
		&& !(video_enable && in_video_window);

	// Half 0 of bank 0 is page zero and ignores the port entirely; half 0
	// of any other bank is an even upper page.
	always_comb begin
		sel_half0 = 1'b0;
		if (half_fitted(1'b0)) begin
			if (BANK == 3'h0) begin
				sel_half0 = in_low_page;
			end else begin
				sel_half0 = upper_gate && upper_page == half_page(1'b0);
			end
		end
	end

	assign sel_half1 = half_fitted(1'b1) && upper_gate
		&& upper_page == half_page(1'b1);

	assign mem_sel = sel_half0 || sel_half1;
	assign sel_half = sel_half1;

	////////////////////////////////////////////////////////////////////////
	// Strobe sequencing.

	logic seq_start;
	logic ras_on;
	logic mux_on;
	logic cas_on;
	logic started;

	// A refresh cycle strobes rows without needing a page match.
	assign seq_start = !memory_cycle_n && (mem_sel || refresh);

	pdb_strobe_seq #(
		.PRECH_CYCLES(PRECH_CYCLES),
		.MUX_CYCLES(MUX_CYCLES),
		.CAS_CYCLES(CAS_CYCLES)
	) u_seq (
		.clk(clk),
		.rst(rst),
		.start(seq_start),
		.refresh(refresh),
		.ras_on(ras_on),
		.mux_on(mux_on),
		.cas_on(cas_on),
		.started(started)
	);

	////////////////////////////////////////////////////////////////////////
	// Cycle context, caught at the start of the row strobe. Holding it
	// keeps the row group and direction steady even if the bus settles
	// late, which would otherwise glitch a second group's row strobe.

	logic ctx_refresh_r;
	logic ctx_write_r;
	logic ctx_half_r;
	logic ctx_a14_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			ctx_refresh_r <= 1'b0;
			ctx_write_r <= 1'b0;
			ctx_half_r <= 1'b0;
			ctx_a14_r <= 1'b0;
		end else if (seq_start && !ras_on && !started) begin
			ctx_refresh_r <= refresh;
			ctx_write_r <= !wr_n && !refresh;
			ctx_half_r <= sel_half;
			ctx_a14_r <= bus_addr[ADDR_ROWGRP_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Array row strobes.

	logic [3:0] ras_row_n_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			ras_row_n_r <= 4'hf;
		end else if (!ras_on) begin
			ras_row_n_r <= 4'hf;
		end else if (ctx_refresh_r) begin
			ras_row_n_r <= 4'h0;
		end else begin
			ras_row_n_r <= ~row_onehot(ctx_half_r, ctx_a14_r);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Address multiplexer and column strobe. Both follow the delay chain
	// through one register each, so their order is kept.

	logic row_column_select_r;
	logic cas_n_r;
	logic [ARRAY_ADDR_W-1:0] array_addr_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			row_column_select_r <= 1'b0;
		end else begin
			row_column_select_r <= mux_on;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cas_n_r <= 1'b1;
		end else begin
			cas_n_r <= !cas_on;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			array_addr_r <= '0;
		end else if (mux_on) begin
			array_addr_r <= bus_addr[COL_ADDR_LSB +: ARRAY_ADDR_W];
		end else begin
			array_addr_r <= bus_addr[ROW_ADDR_LSB +: ARRAY_ADDR_W];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Write path.

	logic array_we_n_r;
	logic [7:0] array_din_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			array_we_n_r <= 1'b1;
		end else begin
			array_we_n_r <= !(ras_on && ctx_write_r && !wr_n);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			array_din_r <= 8'h00;
		end else if (!wr_n) begin
			array_din_r <= bus_data_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read path. Data is taken from the array one cycle after the column
	// strobe falls; the enable comes up with it so the bus never sees a
	// stale byte from an earlier cycle.

	logic bus_data_oe_r;
	logic [7:0] bus_data_out_r;
	logic read_ok;

	assign read_ok = cas_on && !ctx_write_r && !ctx_refresh_r && mem_sel
		&& !memory_cycle_n && !rd_n;

	always_ff @(posedge clk) begin
		if (rst) begin
			bus_data_oe_r <= 1'b0;
		end else begin
			bus_data_oe_r <= read_ok && !cas_n_r;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			bus_data_out_r <= 8'h00;
		end else if (read_ok) begin
			bus_data_out_r <= array_dout;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status.

	logic board_selected_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			board_selected_r <= 1'b0;
		end else begin
			board_selected_r <= !memory_cycle_n && mem_sel;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs.

	assign ras_row_n = ras_row_n_r;
	assign cas_n = cas_n_r;
	assign row_column_select = row_column_select_r;
	assign array_addr = array_addr_r;
	assign array_we_n = array_we_n_r;
	assign array_din = array_din_r;
	assign bus_data_oe = bus_data_oe_r;
	assign bus_data_out = bus_data_out_r;
	assign page_select_port = page_port_r;
	assign board_selected = board_selected_r;

endmodule

// >>> verification/pdb_board_ctrl_assertions.sv
`timescale 1ns/1ps

module pdb_board_ctrl_chk
	import pdb_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Bus side
	input wire logic [15:0] bus_addr,
	input wire logic [7:0] bus_data_in,
	input wire logic memory_cycle_n,
	input wire logic io_cycle_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic refresh_request_n,
	input wire logic bus_data_oe,
	// Array side and status
	input wire logic [3:0] ras_row_n,
	input wire logic cas_n,
	input wire logic row_column_select,
	input wire logic array_we_n,
	input wire logic [7:0] page_select_port
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);

	logic port_wr;
	logic vid_hit;
	assign port_wr = !io_cycle_n && !wr_n && bus_addr[7:0] == PAGE_PORT_ADDR;
	assign vid_hit = bus_addr >= VIDEO_WINDOW_BASE && page_select_port[PORT_VIDEO_BIT];

	////////////////////////////////////////////////////////////////////////
	cas_after_mux_a: assert property ($fell(cas_n) |-> row_column_select)
		else $error("column strobe before address switch");
	mux_after_ras_a: assert property ($rose(row_column_select) |-> ras_row_n != 4'hf)
		else $error("address switch without row strobe");
	cas_timing_a: assert property (($fell(&ras_row_n) && |ras_row_n) ##0
		!memory_cycle_n[*6] |-> !cas_n) else $error("column strobe late");
	refresh_no_cas_a: assert property ((!refresh_request_n && !memory_cycle_n)[*3]
		|-> cas_n && !row_column_select) else $error("column strobe in refresh");
	refresh_rows_a: assert property ($fell(&ras_row_n) && !refresh_request_n
		|-> ras_row_n == 4'h0) else $error("refresh missed a row group");
	oe_read_a: assert property (bus_data_oe |-> !$past(rd_n, 3) && !$past(memory_cycle_n, 3))
		else $error("data driven without read");
	no_write_oe_a: assert property (!array_we_n |-> !bus_data_oe)
		else $error("data driven in write");
	port_load_a: assert property (port_wr |=> page_select_port == $past(bus_data_in))
		else $error("port not loaded");
	port_hold_a: assert property (!port_wr |=> $stable(page_select_port))
		else $error("port changed without write");
	reset_clear_a: assert property (disable iff (1'b0) rst |=> page_select_port == 8'h00)
		else $error("port not cleared");
	video_block_a: assert property ($fell(memory_cycle_n) && refresh_request_n && vid_hit
		|=> (ras_row_n == 4'hf)[*4]) else $error("row strobe in video window");
	precharge_hold_a: assert property ($rose(&ras_row_n) |=> (&ras_row_n)[*7])
		else $error("precharge too short");

	cover property (!bus_data_oe ##1 bus_data_oe);
	cover property (port_wr);
	cover property ($fell(&ras_row_n) && !refresh_request_n);
	cover property ($fell(memory_cycle_n) && refresh_request_n && vid_hit);
	cover property ($rose(&ras_row_n) && !memory_cycle_n);
endmodule

bind pdb_board_ctrl pdb_board_ctrl_chk u_chk (.clk(clk), .rst(rst), .bus_addr(bus_addr),
	.bus_data_in(bus_data_in), .memory_cycle_n(memory_cycle_n), .io_cycle_n(io_cycle_n),
	.rd_n(rd_n), .wr_n(wr_n), .refresh_request_n(refresh_request_n),
	.bus_data_oe(bus_data_oe), .ras_row_n(ras_row_n), .cas_n(cas_n),
	.row_column_select(row_column_select), .array_we_n(array_we_n),
	.page_select_port(page_select_port));

// >>> verification/pdb_cpu_model.sv
`timescale 1ns/1ps

module pdb_cpu_model (
	// Clock
	input wire logic clk,
	// Bus to the board
	output logic [15:0] bus_addr,
	output logic [7:0] bus_data_in,
	output logic memory_cycle_n,
	output logic io_cycle_n,
	output logic rd_n,
	output logic wr_n,
	output logic refresh_request_n,
	// Board answer
	input wire logic [7:0] bus_data_out,
	input wire logic bus_data_oe,
	input wire logic [3:0] ras_row_n,
	input wire logic cas_n,
	input wire logic row_column_select,
	input wire logic array_we_n,
	input wire logic [7:0] array_din
);
	logic [3:0] ras_and;
	logic cas_seen, mux_seen, we_seen, oe_seen;
	logic [7:0] rdata, wdata;
	int ras_wait;

	initial begin
		bus_addr = 16'h0000;
		bus_data_in = 8'h00;
		{memory_cycle_n, io_cycle_n, rd_n, wr_n, refresh_request_n} = 5'h1f;
	end

	////////////////////////////////////////////////////////////////////////
	// Kind 0 memory, 1 I/O, 2 refresh. The bus has no wait line, so a cycle is
	// held for a fixed length; gap idle cycles follow, and a short gap lands
	// the next cycle inside the precharge stretch.
	task automatic cycle(input logic [1:0] k, input logic w, input logic [15:0] a,
		input logic [7:0] d, input int gap = 12);
		@(negedge clk);
		bus_addr = a;
		bus_data_in = d;
		memory_cycle_n = k == 2'd1;
		io_cycle_n = k != 2'd1;
		refresh_request_n = k != 2'd2;
		rd_n = w || k == 2'd2;
		wr_n = !w;
		ras_and = 4'hf;
		{cas_seen, mux_seen, we_seen, oe_seen} = 4'h0;
		rdata = 8'hee;
		wdata = 8'hee;
		ras_wait = 0;
		repeat (16) begin
			@(posedge clk);
			#1;
			ras_and = ras_and & ras_row_n;
			if (&ras_and) ras_wait++;
			cas_seen |= !cas_n;
			mux_seen |= row_column_select;
			we_seen |= !array_we_n;
			oe_seen |= bus_data_oe;
			if (bus_data_oe) rdata = bus_data_out;
			if (!array_we_n) wdata = array_din;
		end
		@(negedge clk);
		{memory_cycle_n, io_cycle_n, rd_n, wr_n, refresh_request_n} = 5'h1f;
		// Released lines show garbage rather than the last value.
		bus_addr = ~a;
		bus_data_in = ~d;
		repeat (gap) @(negedge clk);
	endtask
endmodule

// >>> verification/pdb_board_ctrl_test.sv
`timescale 1ns/1ps

module pdb_board_ctrl_test;
	import pdb_pkg::*;

	logic clk, rst, memory_cycle_n, io_cycle_n, rd_n, wr_n, refresh_request_n;
	logic bus_data_oe, cas_n, row_column_select, array_we_n, board_selected;
	logic [15:0] bus_addr, a;
	logic [7:0] bus_data_in, bus_data_out, array_dout, array_din, page_select_port, p;
	logic [ARRAY_ADDR_W-1:0] array_addr;
	logic [3:0] ras_row_n, r;
	int miscompares, total_checks;
	int sel_cnt, b_sel_cnt, c0, c1;
	logic b_sel;
	// Port value, address, row strobes expected over the cycle.
	logic [27:0] rd_tab [12] = '{{8'h01, 16'h1234, 4'he}, {8'h01, 16'h4080, 4'hd},
		{8'h07, 16'h8100, 4'hf}, {8'h06, 16'h8100, 4'hf},
		{8'h01, 16'h8100, 4'hb}, {8'h01, 16'hffff, 4'h7}, {8'h02, 16'h8000, 4'hf},
		{8'h00, 16'hc000, 4'hf}, {8'h81, 16'hf800, 4'hf}, {8'h81, 16'hf7ff, 4'h7},
		{8'h81, 16'h7800, 4'hd}, {8'h00, 16'h0000, 4'he}};

	// The array answers with its column address only while strobed.
	assign array_dout = cas_n ? ~{1'b0, array_addr} : {1'b0, array_addr};

	pdb_board_ctrl #(.BANK_ID(0), .POP_64K(1'b1), .SINGLE_HALF(1'b0)) u_dut (.clk(clk),
		.rst(rst), .bus_addr(bus_addr), .bus_data_in(bus_data_in),
		.memory_cycle_n(memory_cycle_n), .io_cycle_n(io_cycle_n), .rd_n(rd_n), .wr_n(wr_n),
		.refresh_request_n(refresh_request_n), .bus_data_out(bus_data_out),
		.bus_data_oe(bus_data_oe), .array_dout(array_dout), .array_din(array_din),
		.array_addr(array_addr), .ras_row_n(ras_row_n), .cas_n(cas_n),
		.row_column_select(row_column_select), .array_we_n(array_we_n),
		.page_select_port(page_select_port), .board_selected(board_selected));

	// A second board as bank 3 with only its odd half fitted, so it serves page 7.
	pdb_board_ctrl #(.BANK_ID(3), .POP_64K(1'b0), .SINGLE_HALF(1'b1)) u_dut_b (.clk(clk),
		.rst(rst), .bus_addr(bus_addr), .bus_data_in(bus_data_in),
		.memory_cycle_n(memory_cycle_n), .io_cycle_n(io_cycle_n), .rd_n(rd_n), .wr_n(wr_n),
		.refresh_request_n(refresh_request_n), .bus_data_out(), .bus_data_oe(),
		.array_dout(array_dout), .array_din(), .array_addr(), .ras_row_n(), .cas_n(),
		.row_column_select(), .array_we_n(), .page_select_port(), .board_selected(b_sel));

	pdb_cpu_model u_cpu (.clk(clk), .bus_addr(bus_addr), .bus_data_in(bus_data_in),
		.memory_cycle_n(memory_cycle_n), .io_cycle_n(io_cycle_n), .rd_n(rd_n), .wr_n(wr_n),
		.refresh_request_n(refresh_request_n), .bus_data_out(bus_data_out),
		.bus_data_oe(bus_data_oe), .ras_row_n(ras_row_n), .cas_n(cas_n),
		.row_column_select(row_column_select), .array_we_n(array_we_n),
		.array_din(array_din));

	// Counts of cycles in which each board claims a memory cycle.
	always @(posedge clk) begin
		if (board_selected === 1'b1) sel_cnt++;
		if (b_sel === 1'b1) b_sel_cnt++;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic test_done;
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		test_done();
	end

	initial begin
		rst = 1'b1;
		repeat (12) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		chk("port", 8'h00, page_select_port);
		chk("rows", 8'h0f, {4'h0, ras_row_n});
		$display("reset test done");
		u_cpu.cycle(2'd1, 1'b1, 16'h12ff, 8'h81);
		chk("port", 8'h81, page_select_port);
		u_cpu.cycle(2'd1, 1'b0, 16'h00ff, 8'h00);
		chk("port read oe", 8'h00, {7'h0, u_cpu.oe_seen});
		u_cpu.cycle(2'd1, 1'b1, 16'h00fe, 8'h55);
		chk("port", 8'h81, page_select_port);
		$display("port test done");
		for (int i = 0; i < 12; i++) begin
			{p, a, r} = rd_tab[i];
			u_cpu.cycle(2'd1, 1'b1, 16'h00ff, p);
			c0 = sel_cnt;
			c1 = b_sel_cnt;
			u_cpu.cycle(2'd0, 1'b0, a, 8'h00);
			chk("read sel", {7'h0, r != 4'hf}, {7'h0, sel_cnt != c0});
			chk("bank b sel", {7'h0, p == 8'h07}, {7'h0, b_sel_cnt != c1});
			chk("read rows", {4'h0, r}, {4'h0, u_cpu.ras_and});
			chk("read oe", {7'h0, r != 4'hf}, {7'h0, u_cpu.oe_seen});
			if (r != 4'hf) begin
				chk("read data", {1'b0, a[13:7]}, u_cpu.rdata);
			end
		end
		$display("read test done");
		u_cpu.cycle(2'd1, 1'b1, 16'h00ff, 8'h01);
		u_cpu.cycle(2'd0, 1'b1, 16'h9abc, 8'h3c);
		chk("write we oe", 8'h02, {6'h0, u_cpu.we_seen, u_cpu.oe_seen});
		chk("write data", 8'h3c, u_cpu.wdata);
		u_cpu.cycle(2'd2, 1'b0, 16'h0040, 8'h00);
		chk("refresh rows", 8'h00, {4'h0, u_cpu.ras_and});
		chk("refresh flags", 8'h00, {4'h0, u_cpu.cas_seen, u_cpu.mux_seen, u_cpu.we_seen,
			u_cpu.oe_seen});
		$display("write and refresh test done");
		u_cpu.cycle(2'd0, 1'b0, 16'h1234, 8'h00, 0);
		u_cpu.cycle(2'd0, 1'b0, 16'h1234, 8'h00);
		chk("held rows", 8'h0e, {4'h0, u_cpu.ras_and});
		chk("held ras wait", 8'(PRECH_CYC + 1), 8'(u_cpu.ras_wait));
		chk("held read data", 8'h24, u_cpu.rdata);
		$display("precharge test done");
		rst = 1'b1;
		@(negedge clk);
		rst = 1'b0;
		chk("port", 8'h00, page_select_port);
		$display("second reset test done");
		test_done();
	end
endmodule
